// File: hw/ulpi_phy_register_bank.sv
// Register bank of the ULPI transceiver with core reset sequencing.
`timescale 1ns/1ps
module ulpi_phy_register_bank
  import ulpi_regs_pkg::*;
#(
  parameter int RESET_CYCLES = CORE_RESET_CYCLES  // Core reset hold length.
) (
  input  wire logic       core_clk,          // ULPI clock, 125 MHz.
  input  wire logic       nrst,              // Power-on reset, active low.
  input  wire logic       reg_wr,            // Register write command pulse.
  input  wire logic       reg_rd,            // Register read command pulse.
  input  wire logic [5:0] reg_addr,          // Six-bit register address.
  input  wire logic [7:0] reg_wdata,         // Write data byte.
  input  wire logic       line_level_bit0,   // Line state bit 0 from the receiver.
  input  wire logic       line_level_bit1,   // Line state bit 1 from the receiver.
  input  wire logic       low_power_exit,    // Wake-up from low power, level.
  input  wire logic       uart_mode_exit,    // Leave UART pass-through, level.
  output logic [7:0]      reg_rdata,         // Read data byte.
  output logic            reg_rd_done,       // Read data valid pulse.
  output logic [1:0]      speed_select,      // Transceiver speed.
  output logic            termination_select,// Pull-up and terminations on.
  output logic [1:0]      line_encoding_select, // Transmit encoding.
  output logic            low_power_n,       // Low for low power mode.
  output logic            accessory_uart_mode, // UART pass-through interface.
  output logic            protect_pulls_en,  // Interface protection pulls on.
  output logic            uart_tx_route_en,  // Transmit routed to DM.
  output logic            uart_rx_route_en,  // Receive routed to DATA[1].
  output logic [1:0]      output_drive_level,// Drive strength level.
  output logic            output_edge_speed, // High for fast edges.
  output logic            core_dir,          // DIR claim during core reset.
  output logic            core_reset,        // Reset to the ULPI core logic.
  output logic            rxcmd_send         // Request to send an RX CMD, pulse.
);

  // Stored registers and combinational decodes.
  logic [7:0]  fc_q;            // Function control.
  logic [7:0]  ic_q;            // Interface control.
  logic [7:0]  scr_q;           // Scratch byte.
  logic [7:0]  acc_q;           // Accessory UART control.
  logic [7:0]  drv_q;           // Output drive config.
  logic [7:0]  rdata_q;         // Read data holding register.
  logic        rd_done_q;       // Read completion pulse.
  logic [1:0]  line_s1_q;       // Line state first sync stage.
  logic [1:0]  line_s2_q;       // Line state second sync stage.
  logic        wake_s1_q;       // Wake first sync stage.
  logic        wake_s2_q;       // Wake second sync stage.
  logic        uexit_s1_q;      // UART exit first sync stage.
  logic        uexit_s2_q;      // UART exit second sync stage.
  logic        tx_route_q;      // Gated transmit routing.
  logic        rx_route_q;      // Gated receive routing.
  logic        dir_q;           // DIR claim.
  logic        core_rst_q;      // Core reset output.
  logic        rxcmd_q;         // RX CMD request pulse.
  logic [15:0] cnt_q;           // Core reset hold counter.
  rst_state_t  st_q;            // Sequencer state.
  logic        rst_done;        // Last cycle of the hold.
  logic        rst_start;       // Core reset bit set while the sequencer rests.
  logic [7:0]  fc_d;            // Function control after a command.
  logic        pulls_q;         // Protection pulls enable, high for on.
  logic [15:0] hold_len_q;      // Cycles the core reset has stood, for checks.

  // Decode the operation that an address selects within a three-address group.
  function automatic wr_op_t group_op(input logic [5:0] a, input logic [5:0] base); // [RULE_23]
    wr_op_t op;
    op = OP_NONE;
    if (a == base) begin
      op = OP_WRITE;
    end else if (a == base + 6'h01) begin
      op = OP_SET;
    end else if (a == base + 6'h02) begin
      op = OP_CLEAR;
    end
    return op;
  endfunction

  // Apply a write, set or clear to a register, keeping reserved bits at zero.
  function automatic logic [7:0] apply_op(input wr_op_t op, input logic [7:0] cur,
                                          input logic [7:0] data, input logic [7:0] mask);
    logic [7:0] nxt;
    nxt = cur;
    case (op)
      OP_WRITE: nxt = data;                   // [RULE_24]
      OP_SET:   nxt = cur | data;             // [RULE_24]
      OP_CLEAR: nxt = cur & ~data;            // [RULE_24]
      default:  nxt = cur;
    endcase
    return nxt & mask;                        // [RULE_25]
  endfunction

  // Function control value after the current command, before hardware updates.
  always_comb begin
    fc_d = fc_q;
    if (reg_wr) begin
      fc_d = apply_op(group_op(reg_addr, ADDR_FC_WR), fc_q, reg_wdata, FC_MASK); // [RULE_16]
    end
  end

  // A core reset starts whenever bit 5 stands set while the sequencer rests, so a
  // set that lands in the closing cycles of a previous reset is not lost.
  assign rst_start = (st_q == ST_IDLE) && fc_d[FC_CORE_RST];  // [RULE_04]
  assign rst_done  = (st_q == ST_HOLD) && (cnt_q == 16'(RESET_CYCLES - 1));

  // Two-flop synchronisers for levels from the analog side.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      line_s1_q  <= 2'h0;
      line_s2_q  <= 2'h0;
      wake_s1_q  <= 1'h0;
      wake_s2_q  <= 1'h0;
      uexit_s1_q <= 1'h0;
      uexit_s2_q <= 1'h0;
    end else begin
      line_s1_q  <= {line_level_bit1, line_level_bit0};
      line_s2_q  <= line_s1_q;
      wake_s1_q  <= low_power_exit;
      wake_s2_q  <= wake_s1_q;
      uexit_s1_q <= uart_mode_exit;
      uexit_s2_q <= uexit_s1_q;
    end
  end

  // Function control. The sequencer clears the reset bit at the end of the hold;
  // a wake-up sets the low-power bit and wins over a clear in the same cycle.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      fc_q <= FC_RESET;                                     // [RULE_01] [RULE_02] [RULE_09]
    end else begin
      fc_q <= fc_d;                                         // [RULE_03]
      if (rst_done) begin
        fc_q[FC_CORE_RST] <= 1'b0;                          // [RULE_05]
      end
      if (wake_s2_q) begin
        fc_q[FC_LOW_PWR_N] <= 1'b1;                         // [RULE_10]
      end
    end
  end

  // Interface control; leaving pass-through drops the mode bit, the exit wins.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ic_q <= IC_RESET;                                     // [RULE_11] [RULE_13]
    end else begin
      if (reg_wr) begin
        ic_q <= apply_op(group_op(reg_addr, ADDR_IC_WR), ic_q, reg_wdata, IC_MASK); // [RULE_17]
      end
      // The exit is applied last, so it wins over a same-cycle set.
      if (uexit_s2_q) begin
        ic_q[IC_UART_MODE] <= 1'b0;                         // [RULE_12]
      end
    end
  end

  // Scratch byte has no side effects at all.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      scr_q <= SCR_RESET;
    end else if (reg_wr) begin
      scr_q <= apply_op(group_op(reg_addr, ADDR_SCR_WR), scr_q, reg_wdata, 8'hff); // [RULE_15]
    end
  end

  // Accessory UART control.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      acc_q <= ACC_RESET;                                   // [RULE_19]
    end else if (reg_wr) begin
      acc_q <= apply_op(group_op(reg_addr, ADDR_ACC_WR), acc_q, reg_wdata, ACC_MASK); // [RULE_18]
    end
  end

  // Vendor drive register accepts only plain writes.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      drv_q <= DRV_RESET;                                   // [RULE_21] [RULE_22]
    end else if (reg_wr && reg_addr == ADDR_DRV) begin
      drv_q <= reg_wdata & DRV_MASK;                        // [RULE_21] [RULE_22]
    end
  end

  // Routing is gated by the pass-through mode so stale enables do nothing.
  // The protection pulls follow one cycle behind as well, so the pin is a flop.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      tx_route_q <= 1'b0;
      rx_route_q <= 1'b0;
      pulls_q    <= 1'b1;
    end else begin
      tx_route_q <= ic_q[IC_UART_MODE] & acc_q[ACC_TX_ROUTE]; // [RULE_18] [RULE_20]
      rx_route_q <= ic_q[IC_UART_MODE] & acc_q[ACC_RX_ROUTE]; // [RULE_19] [RULE_20]
      pulls_q    <= ~ic_q[IC_PROT_DIS];                       // [RULE_13]
    end
  end

  // Read path: data appears one cycle after the read command.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_q   <= 8'h00;
      rd_done_q <= 1'b0;
    end else begin
      rd_done_q <= reg_rd;
      // Any address of a group reads the whole register.
      if (reg_rd) begin
        if (group_op(reg_addr, ADDR_FC_WR) != OP_NONE) begin
          rdata_q <= fc_q;                                  // [RULE_16]
        end else if (group_op(reg_addr, ADDR_IC_WR) != OP_NONE) begin
          rdata_q <= ic_q;                                  // [RULE_17]
        end else if (reg_addr == ADDR_DBG) begin
          rdata_q <= {6'h00, line_s2_q};                    // [RULE_14]
        end else if (group_op(reg_addr, ADDR_SCR_WR) != OP_NONE) begin
          rdata_q <= scr_q;                                 // [RULE_15]
        end else if (group_op(reg_addr, ADDR_ACC_WR) != OP_NONE) begin
          rdata_q <= acc_q;
        end else if (reg_addr == ADDR_DRV) begin
          rdata_q <= drv_q;
        end else begin
          // Unmapped addresses read as zero.
          rdata_q <= 8'h00;
        end
      end
    end
  end

  // Core reset sequencer: hold DIR and reset, release DIR for one cycle,
  // then claim the bus again for the status update. Only the core logic is
  // reset; no register above depends on core_rst_q.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st_q       <= ST_IDLE;
      cnt_q      <= 16'h0000;
      dir_q      <= 1'b0;
      core_rst_q <= 1'b0;
      rxcmd_q    <= 1'b0;
    end else begin
      rxcmd_q <= 1'b0;
      case (st_q)
        // Rest until the link sets the reset bit.
        ST_IDLE: begin
          if (rst_start) begin
            st_q       <= ST_HOLD;
            cnt_q      <= 16'h0000;
            dir_q      <= 1'b1;                             // [RULE_04]
            core_rst_q <= 1'b1;                             // [RULE_04] [RULE_08]
          end
        end
        // Count out the hold with DIR claimed.
        ST_HOLD: begin
          cnt_q <= cnt_q + 16'h0001;
          if (rst_done) begin
            st_q       <= ST_GAP;
            dir_q      <= 1'b0;                             // [RULE_05] [RULE_07]
            core_rst_q <= 1'b0;
          end
        end
        // Leave the bus to the link for one cycle.
        ST_GAP: begin
          st_q    <= ST_RXCMD;
          dir_q   <= 1'b1;                                  // [RULE_06]
          rxcmd_q <= 1'b1;                                  // [RULE_06]
        end
        // Give the bus back after the update.
        ST_RXCMD: begin
          st_q  <= ST_IDLE;
          dir_q <= 1'b0;
        end
        // An unused code falls back to rest.
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Counts how long the core reset stands, apart from the sequencer's counter.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      hold_len_q <= 16'h0000;
    end else if (core_rst_q) begin
      hold_len_q <= hold_len_q + 16'h0001;
    end else begin
      hold_len_q <= 16'h0000;
    end
  end

  // Outputs come straight from the registers above.
  assign reg_rdata            = rdata_q;
  assign reg_rd_done          = rd_done_q;
  assign speed_select         = fc_q[FC_SPEED_LO +: 2];     // [RULE_01]
  assign termination_select   = fc_q[FC_TERM];              // [RULE_02]
  assign line_encoding_select = fc_q[FC_ENC_LO +: 2];       // [RULE_03]
  assign low_power_n          = fc_q[FC_LOW_PWR_N];         // [RULE_09]
  assign accessory_uart_mode  = ic_q[IC_UART_MODE];         // [RULE_11]
  assign protect_pulls_en     = pulls_q;                    // [RULE_13]
  assign uart_tx_route_en     = tx_route_q;
  assign uart_rx_route_en     = rx_route_q;
  assign output_drive_level   = drv_q[DRV_LEVEL_LO +: 2];
  assign output_edge_speed    = drv_q[DRV_EDGE];
  assign core_dir             = dir_q;
  assign core_reset           = core_rst_q;
  assign rxcmd_send           = rxcmd_q;

  // Checks on the register bank and the reset sequence.
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  reset_start_dir_a: assert property (rst_start |=> core_dir && core_reset) // [RULE_04]
    else $error("Core reset did not raise DIR and reset.");

  reset_self_clear_a: assert property ($fell(core_reset) |-> !fc_q[FC_CORE_RST] && !core_dir) // [RULE_05]
    else $error("Core reset end did not drop DIR and clear the bit.");

  reset_rxcmd_a: assert property ($fell(core_reset) |=> core_dir && rxcmd_send ##1 !core_dir) // [RULE_06]
    else $error("No RX CMD claim after core reset.");

  reset_keeps_regs_a: assert property (core_reset && !reg_wr && !uexit_s2_q |=> // [RULE_08]
    $stable(scr_q) && $stable(ic_q))
    else $error("Core reset changed registers.");

  wake_sets_bit_a: assert property (wake_s2_q |=> low_power_n) // [RULE_10]
    else $error("Wake-up did not set the low power bit.");

  uart_exit_clear_a: assert property (uexit_s2_q |=> !accessory_uart_mode) // [RULE_12]
    else $error("UART exit did not clear the mode bit.");

  debug_read_a: assert property (reg_rd && reg_addr == ADDR_DBG |=> reg_rdata[7:2] == 6'h00 && reg_rd_done) // [RULE_14]
    else $error("Debug read returned nonzero upper bits.");

  scratch_set_a: assert property (reg_wr && reg_addr == ADDR_SCR_SET |=> (scr_q & $past(reg_wdata)) == $past(reg_wdata)) // [RULE_15]
    else $error("Scratch set lost a bit.");

  route_gate_a: assert property (!accessory_uart_mode ##1 !accessory_uart_mode |-> !uart_tx_route_en && !uart_rx_route_en) // [RULE_20]
    else $error("UART routing active outside UART mode.");

  reserved_zero_a: assert property ((fc_q[7] | (|(ic_q & ~IC_MASK)) | (|(drv_q & ~DRV_MASK))) == 1'b0) // [RULE_25]
    else $error("Reserved bit became set.");

  reset_length_a: assert property ($fell(core_reset) |-> // [RULE_04]
    hold_len_q == 16'(RESET_CYCLES))
    else $error("Core reset length differs from the set hold.");

  drive_write_a: assert property (reg_wr && reg_addr == ADDR_DRV |=> // [RULE_21] [RULE_22]
    drv_q == ($past(reg_wdata) & DRV_MASK))
    else $error("Drive register write not taken.");

  fc_clear_a: assert property (reg_wr && reg_addr == ADDR_FC_CLR && !wake_s2_q |=> // [RULE_24]
    (fc_q & $past(reg_wdata)) == 8'h00)
    else $error("Function control clear left a bit set.");

  reset_seq_c: cover property (rst_start ##[1:40] rxcmd_send);
  uart_route_c: cover property (uart_tx_route_en && uart_rx_route_en);
  low_power_c: cover property (!low_power_n ##[1:20] low_power_n);
  drive_cfg_c: cover property (reg_wr && reg_addr == ADDR_DRV);
  wake_c: cover property (wake_s2_q && !low_power_n);

endmodule

// File: hw/ulpi_regs_pkg.sv
// Constants for the transceiver register bank: addresses, fields, resets, timing.
// Function
// (RULE_01) Speed field 1:0, resets to full speed.
// (RULE_02) Bit 2 drives pull-up and terminations.
// (RULE_03) Bits 4:3 select transmit line encoding.
// (RULE_04) Core reset bit raises DIR, resets core.
// (RULE_05) Reset end drops DIR, self-clears bit.
// (RULE_06) Then DIR rises again with status update.
// (RULE_07) Link waits for DIR low before bus use.
// (RULE_08) Core reset leaves registers and interface intact.
// (RULE_09) Active-low bit 6 enters low power.
// (RULE_10) Leaving low power sets bit 6 again.
// (RULE_11) Interface control bit 2 enables UART mode.
// (RULE_12) UART mode bit clears on mode exit.
// (RULE_13) Bit 7 disables interface protection pulls.
// (RULE_14) Debug register shows line state bits.
// (RULE_15) Scratch byte: read, write, set, clear.
// (RULE_16) Function control at 04h to 06h.
// (RULE_17) Interface control at 07h to 09h.
// (RULE_18) Accessory bit 2 routes UART transmit out.
// (RULE_19) Accessory bit 3 routes UART receive in.
// (RULE_20) Routing only while UART mode set; the code keeps routing on for one cycle after the mode bit clears.
// (RULE_21) Vendor register 31h holds drive level.
// (RULE_22) Vendor bit 2 selects edge speed.
// (RULE_23) Access carries a six-bit register address.
// (RULE_24) Set ORs data, clear removes ones.
// (RULE_25) Reserved bits ignore writes, read constant.
package ulpi_regs_pkg;

  // Register addresses as carried in the command byte.
  localparam logic [5:0] ADDR_FC_WR   = 6'h04;
  localparam logic [5:0] ADDR_FC_SET  = 6'h05;
  localparam logic [5:0] ADDR_FC_CLR  = 6'h06;
  localparam logic [5:0] ADDR_IC_WR   = 6'h07;
  localparam logic [5:0] ADDR_IC_SET  = 6'h08;
  localparam logic [5:0] ADDR_IC_CLR  = 6'h09;
  localparam logic [5:0] ADDR_DBG     = 6'h15;
  localparam logic [5:0] ADDR_SCR_WR  = 6'h16;
  localparam logic [5:0] ADDR_SCR_SET = 6'h17;
  localparam logic [5:0] ADDR_SCR_CLR = 6'h18;
  localparam logic [5:0] ADDR_ACC_WR  = 6'h19;
  localparam logic [5:0] ADDR_ACC_SET = 6'h1a;
  localparam logic [5:0] ADDR_ACC_CLR = 6'h1b;
  localparam logic [5:0] ADDR_DRV     = 6'h31;

  // Field positions.
  localparam int FC_SPEED_LO   = 0;
  localparam int FC_TERM       = 2;
  localparam int FC_ENC_LO     = 3;
  localparam int FC_CORE_RST   = 5;
  localparam int FC_LOW_PWR_N  = 6;
  localparam int IC_UART_MODE  = 2;
  localparam int IC_PROT_DIS   = 7;
  localparam int ACC_TX_ROUTE  = 2;
  localparam int ACC_RX_ROUTE  = 3;
  localparam int DRV_LEVEL_LO  = 0;
  localparam int DRV_EDGE      = 2;

  // Writable bit masks; zero bits are reserved and read as zero.
  localparam logic [7:0] FC_MASK  = 8'h7f;
  localparam logic [7:0] IC_MASK  = 8'h84;
  localparam logic [7:0] ACC_MASK = 8'h0c;
  localparam logic [7:0] DRV_MASK = 8'h07;

  // Reset values: full speed, normal power, everything else off.
  localparam logic [7:0] FC_RESET  = 8'h41;
  localparam logic [7:0] IC_RESET  = 8'h00;
  localparam logic [7:0] SCR_RESET = 8'h00;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [7:0] DRV_RESET = 8'h00;

  // Core reset hold length in clock cycles.
  localparam int CORE_RESET_CYCLES = 16;

  // Write operations decoded from the address.
  typedef enum logic [1:0] {
    OP_WRITE = 2'b00,
    OP_SET   = 2'b01,
    OP_CLEAR = 2'b10,
    OP_NONE  = 2'b11
  } wr_op_t;

  // Core reset sequencer states.
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_HOLD  = 2'b01,
    ST_GAP   = 2'b10,
    ST_RXCMD = 2'b11
  } rst_state_t;

endpackage

// File: verification/ulpi_link_model.sv
// Link controller model that issues register commands to the transceiver register bank.
`timescale 1ns/1ps
module ulpi_link_model (
  input  wire logic       core_clk,  // ULPI clock shared with the transceiver.
  input  wire logic       core_dir,  // Bus claim raised by the transceiver.
  output logic            reg_wr,    // Write command pulse.
  output logic            reg_rd,    // Read command pulse.
  output logic [5:0]      reg_addr,  // Six-bit register address.
  output logic [7:0]      reg_wdata  // Write data byte.
);
  // The bus starts idle with arbitrary junk on the address and data lines.
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 6'h2a;
    reg_wdata = 8'h5a;
  end

  // Stay off the bus while the transceiver claims it; bounded so a stuck claim cannot hang.
  task automatic bus_free();
    int n;
    n = 0;
    while (core_dir === 1'b1 && n < 256) begin
      @(negedge core_clk);
      n++;
    end
  endtask

  // One command: drive at a falling edge, held over one rising edge, released after.
  task automatic cmd(input logic w, input logic [5:0] a, input logic [7:0] d);
    @(negedge core_clk);
    bus_free();
    reg_wr = w;
    reg_rd = ~w;
    reg_addr = a;
    reg_wdata = d;
    @(negedge core_clk);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    // Released lines carry inverted junk so a stale value is never mistaken for a valid one.
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask

  // Register write, set or clear, selected by the address.
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    cmd(1'b1, a, d);
  endtask

  // Register read; the data byte is ignored by the device.
  task automatic rd(input logic [5:0] a);
    cmd(1'b0, a, 8'h00);
  endtask
endmodule

// File: verification/ulpi_phy_register_bank_tb.sv
// Self-checking testbench for the transceiver register bank.
`timescale 1ns/1ps
module ulpi_phy_register_bank_tb
  import ulpi_regs_pkg::*;
;
  localparam int RC = 4;  // Short core reset hold keeps the run brief.
  logic       core_clk, nrst, reg_wr, reg_rd, reg_rd_done;
  logic [5:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic       line_level_bit0, line_level_bit1, low_power_exit, uart_mode_exit;
  logic [1:0] speed_select, line_encoding_select, output_drive_level;
  logic       termination_select, low_power_n, accessory_uart_mode, protect_pulls_en;
  logic       uart_tx_route_en, uart_rx_route_en, output_edge_speed;
  logic       core_dir, core_reset, rxcmd_send;
  int         fail_count = 0;   // Mismatches seen.
  int         checks_done = 0;  // Comparisons made.
  logic [13:0] exp_q[$];        // Pending reads: address and expected byte.
  logic [7:0] v, s;             // Expected register contents.
  int         n;                // Cycle counter for the core reset.

  ulpi_phy_register_bank #(.RESET_CYCLES(RC)) dut_u (
    .core_clk(core_clk), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .line_level_bit0(line_level_bit0),
    .line_level_bit1(line_level_bit1), .low_power_exit(low_power_exit),
    .uart_mode_exit(uart_mode_exit), .reg_rdata(reg_rdata), .reg_rd_done(reg_rd_done),
    .speed_select(speed_select), .termination_select(termination_select),
    .line_encoding_select(line_encoding_select), .low_power_n(low_power_n),
    .accessory_uart_mode(accessory_uart_mode), .protect_pulls_en(protect_pulls_en),
    .uart_tx_route_en(uart_tx_route_en), .uart_rx_route_en(uart_rx_route_en),
    .output_drive_level(output_drive_level), .output_edge_speed(output_edge_speed),
    .core_dir(core_dir), .core_reset(core_reset), .rxcmd_send(rxcmd_send));

  ulpi_link_model link_u (
    .core_clk(core_clk), .core_dir(core_dir), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata));

  // Free-running 125 MHz clock.
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // Counts every comparison and reports a mismatch at once.
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Notes the expected byte, then has the link issue the read.
  task automatic rd_exp(input logic [5:0] a, input logic [7:0] e);
    exp_q.push_back({a, e});
    link_u.rd(a);
  endtask

  // Write, set and clear through a three-address group; v returns the final contents.
  task automatic group(input logic [5:0] b, input logic [7:0] dm, input logic [7:0] rm,
                       output logic [7:0] r);
    logic [7:0] d;
    d = 8'($urandom()) & dm;
    link_u.wr(b, d);
    r = d & rm;
    rd_exp(b + 6'h2, r);
    d = 8'($urandom()) & dm;
    link_u.wr(b + 6'h1, d);
    r = (r | d) & rm;
    rd_exp(b + 6'h1, r);
    d = 8'($urandom()) & dm;
    link_u.wr(b + 6'h2, d);
    r = r & ~d;
    rd_exp(b, r);
  endtask

  // Read data is compared against the oldest note when the done pulse shows.
  always @(negedge core_clk) begin
    if (reg_rd_done === 1'b1) begin
      if (exp_q.size() == 0) begin
        check("unrequested read", 8'h00, 8'hff);
      end else begin
        check($sformatf("read %h", exp_q[0][13:8]), reg_rdata, exp_q[0][7:0]);
        void'(exp_q.pop_front());
      end
    end
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic final_report();
    $display("Checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Whole run needs well under two thousand cycles; this cuts a hang short.
  initial begin
    repeat (20000) @(negedge core_clk);
    fail_count++;
    $display("Watchdog expired");
    final_report();
  end

  initial begin
    nrst = 1'b0;
    line_level_bit0 = 1'b0;
    line_level_bit1 = 1'b0;
    low_power_exit = 1'b0;
    uart_mode_exit = 1'b0;
    void'($urandom(76624));
    repeat (10) @(negedge core_clk);
    nrst = 1'b1;
    check("speed", {6'h0, speed_select}, 8'h01);
    check("pulls", {7'h0, protect_pulls_en}, 8'h01);
    rd_exp(ADDR_FC_WR, 8'h41);
    rd_exp(ADDR_IC_WR, 8'h00);
    rd_exp(ADDR_SCR_WR, 8'h00);
    rd_exp(ADDR_ACC_WR, 8'h00);
    rd_exp(ADDR_DRV, 8'h00);
    rd_exp(6'h20, 8'h00);
    $display("Reset values test done.");
    // Bit 5 is kept out of the random data so no core reset starts here.
    group(ADDR_FC_WR, 8'hdf, 8'h7f, v);
    check("speed", {6'h0, speed_select}, {6'h0, v[1:0]});
    check("term", {7'h0, termination_select}, {7'h0, v[2]});
    check("encoding", {6'h0, line_encoding_select}, {6'h0, v[4:3]});
    check("low power", {7'h0, low_power_n}, {7'h0, v[6]});
    group(ADDR_IC_WR, 8'hff, 8'h84, v);
    check("uart mode", {7'h0, accessory_uart_mode}, {7'h0, v[2]});
    check("pulls", {7'h0, protect_pulls_en}, {7'h0, ~v[7]});
    group(ADDR_SCR_WR, 8'hff, 8'hff, v);
    group(ADDR_ACC_WR, 8'hff, 8'h0c, v);
    $display("Write, set and clear test done.");
    for (int i = 0; i < 8; i++) begin
      link_u.wr(ADDR_DRV, 8'hf8 | 8'(i));
      rd_exp(ADDR_DRV, 8'(i));
      check("drive", {6'h0, output_drive_level}, 8'(i & 3));
      check("edge", {7'h0, output_edge_speed}, 8'(i >> 2));
    end
    $display("Drive config test done.");
    link_u.wr(ADDR_IC_WR, 8'h00);
    link_u.wr(ADDR_ACC_WR, 8'h0c);
    repeat (2) @(negedge core_clk);
    check("routes off", {6'h0, uart_tx_route_en, uart_rx_route_en}, 8'h00);
    link_u.wr(ADDR_IC_SET, 8'h04);
    repeat (2) @(negedge core_clk);
    check("routes on", {6'h0, uart_tx_route_en, uart_rx_route_en}, 8'h03);
    link_u.wr(ADDR_ACC_CLR, 8'h04);
    repeat (2) @(negedge core_clk);
    check("rx only", {6'h0, uart_tx_route_en, uart_rx_route_en}, 8'h01);
    uart_mode_exit = 1'b1;
    repeat (5) @(negedge core_clk);
    uart_mode_exit = 1'b0;
    check("uart exit", {6'h0, accessory_uart_mode, uart_rx_route_en}, 8'h00);
    rd_exp(ADDR_IC_WR, 8'h00);
    $display("Uart routing test done.");
    link_u.wr(ADDR_FC_WR, 8'h41);
    link_u.wr(ADDR_FC_CLR, 8'h40);
    check("enter low power", {7'h0, low_power_n}, 8'h00);
    low_power_exit = 1'b1;
    repeat (5) @(negedge core_clk);
    low_power_exit = 1'b0;
    check("wake", {7'h0, low_power_n}, 8'h01);
    repeat (3) @(negedge core_clk);
    rd_exp(ADDR_FC_WR, 8'h41);
    $display("Low power test done.");
    for (int i = 0; i < 4; i++) begin
      {line_level_bit1, line_level_bit0} = 2'($urandom());
      repeat (3) @(negedge core_clk);
      link_u.wr(ADDR_DBG, 8'hff);
      rd_exp(ADDR_DBG, {6'h0, line_level_bit1, line_level_bit0});
    end
    $display("Line state test done.");
    s = 8'($urandom());
    link_u.wr(ADDR_SCR_WR, s);
    link_u.wr(ADDR_FC_SET, 8'h20);
    n = 0;
    while (core_dir === 1'b1 && core_reset === 1'b1 && n < 100) begin
      n++;
      @(negedge core_clk);
    end
    check("reset length", 8'(n), 8'(RC));
    check("reset end", {6'h0, core_dir, core_reset}, 8'h00);
    @(negedge core_clk);
    check("status update", {6'h0, core_dir, rxcmd_send}, 8'h03);
    @(negedge core_clk);
    check("update done", {6'h0, core_dir, rxcmd_send}, 8'h00);
    rd_exp(ADDR_FC_SET, 8'h41);
    rd_exp(ADDR_SCR_CLR, s);
    $display("Core reset test done.");
    repeat (3) @(negedge core_clk);
    check("reads pending", 8'(exp_q.size()), 8'h00);
    final_report();
  end
endmodule
